//--- rsse_map.svh
// Offsets, field positions and reset values of the execution block.
// Assumes a 32-bit APB bus with byte addresses and word-aligned registers.
// Notes on behaviour
// (RQ1) Rotate right selects file register through carry; old carry enters bit 7.
// (RQ2) Rotate destination 0 writes the accumulator; 1 writes back the file register.
// (RQ3) Sleep halts the oscillator within one cycle; only power-down flag changes.
// (RQ4) While asleep, an active external interrupt restarts the clock and execution.
// (RQ5) Software clears pending interrupt flags before issuing sleep.
// (RQ6) Software places a no-operation after sleep; the wake slot is treated so.
// (RQ7) Literal minus accumulator is written into the accumulator in one cycle.
// (RQ8) Subtract sets carry on no borrow, zero on an all-zero result.
// (RQ9) Digit carry is set when no borrow passes from bit 3 to bit 4.
// (RQ10) Sleep clears the power-down flag so software can see it slept.
`ifndef RSSE_MAP_SVH
`define RSSE_MAP_SVH

`define RSSE_ADDR_W 12
`define RSSE_OFS_ACC 12'h000
`define RSSE_OFS_FILE 12'h004
`define RSSE_OFS_STATUS 12'h008
`define RSSE_OFS_CMD 12'h00c

// Status register fields
`define RSSE_ST_C 0
`define RSSE_ST_DC 1
`define RSSE_ST_Z 2
`define RSSE_ST_PD 3
`define RSSE_ST_ASLEEP 4

// Command register fields
`define RSSE_CMD_OP_LO 0
`define RSSE_CMD_OP_HI 1
`define RSSE_CMD_DEST 2
`define RSSE_CMD_LIT_LO 8
`define RSSE_CMD_LIT_HI 15

// Reset values
`define RSSE_RST_ACC 8'h00
`define RSSE_RST_FILE 8'h00
`define RSSE_RST_PD 1'b1

`endif

//--- rsse_pkg.sv
// Types shared by the execution block and its arithmetic unit.
// Assumes the map header supplies the command field positions; the op encodings are defined here.
package rsse_pkg;

  typedef enum logic [1:0] {
    no_operation_op = 2'h0,
    rotate_right_carry_op = 2'h1,
    literal_minus_acc_op = 2'h2,
    sleep_op = 2'h3
  } rsse_op_type;

  typedef enum logic {
    rsse_running,
    rsse_asleep
  } rsse_state_type;

endpackage

//--- rsse_alu.sv
// Combinational rotate and subtract unit with flag results.
// Assumes operands are held stable by the caller for the whole cycle.
`timescale 1ns/1ps
module rsse_alu
  import rsse_pkg::*;
#(
  parameter int DATA_W = 8
) (
  input wire logic [DATA_W-1:0] file_val,
  input wire logic [DATA_W-1:0] acc_val,
  input wire logic [DATA_W-1:0] literal,
  input wire logic carry_in,
  output logic [DATA_W-1:0] rot_res,
  output logic rot_carry,
  output logic [DATA_W-1:0] sub_res,
  output logic sub_carry,
  output logic sub_dcarry,
  output logic sub_zero
);

  if (DATA_W < 5) begin : g_width_chk
    $error("rsse_alu needs at least 5 data bits");
  end

  logic [DATA_W:0] diff;
  logic [4:0] nib_diff;

  assign rot_res = {carry_in, file_val[DATA_W-1:1]}; // RQ1
  assign rot_carry = file_val[0]; // RQ1

  // Extra top bit catches the borrow
  assign diff = {1'b0, literal} - {1'b0, acc_val}; // RQ7
  assign sub_res = diff[DATA_W-1:0];
  assign sub_carry = ~diff[DATA_W]; // RQ8
  assign nib_diff = {1'b0, literal[3:0]} - {1'b0, acc_val[3:0]};
  assign sub_dcarry = ~nib_diff[4]; // RQ9
  assign sub_zero = (diff[DATA_W-1:0] == '0); // RQ8

endmodule

//--- rsse_exec.sv
// Execution block for rotate-right, literal subtract and sleep.
// Assumes an APB master on core_clk; wake_irq is a synchronous level.
//
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "rsse_map.svh"
module rsse_exec
  import rsse_pkg::*;
#(
  parameter int DATA_W = 8
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`RSSE_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic wake_irq,
  output logic osc_run,
  output logic [DATA_W-1:0] acc_out,
  output logic [DATA_W-1:0] file_out
);

  if (DATA_W != 8) begin : g_width_chk
    $error("rsse_exec supports an 8-bit datapath only");
  end

  logic [DATA_W-1:0] acc_q;
  logic [DATA_W-1:0] file_q;
  logic c_q;
  logic dc_q;
  logic z_q;
  logic pd_q;
  logic skip_q;
  rsse_state_type state_q;
  logic [31:0] prdata_q;

  logic access;
  logic wr;
  logic rd_setup;
  logic addr_ok;
  logic cmd_wr;
  logic exec;
  rsse_op_type op;
  logic dest;
  logic [DATA_W-1:0] literal;
  logic [DATA_W-1:0] rot_res;
  logic rot_carry;
  logic [DATA_W-1:0] sub_res;
  logic sub_carry;
  logic sub_dcarry;
  logic sub_zero;

  // Zero wait states; every access completes in its first access cycle
  assign access = psel & penable;
  assign wr = access & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign addr_ok = (paddr == `RSSE_OFS_ACC) | (paddr == `RSSE_OFS_FILE) |
                   (paddr == `RSSE_OFS_STATUS) | (paddr == `RSSE_OFS_CMD);
  assign pready = access;
  assign pslverr = access & ~addr_ok;

  assign cmd_wr = wr & (paddr == `RSSE_OFS_CMD);
  // Commands are dropped while asleep and in the slot after a wake
  assign exec = cmd_wr & (state_q == rsse_running) & ~skip_q; // RQ6
  assign op = rsse_op_type'(pwdata[`RSSE_CMD_OP_HI:`RSSE_CMD_OP_LO]);
  assign dest = pwdata[`RSSE_CMD_DEST];
  assign literal = pwdata[`RSSE_CMD_LIT_HI:`RSSE_CMD_LIT_LO];

  rsse_alu #(
    .DATA_W(DATA_W)
  ) i_rsse_alu (
    .file_val(file_q),
    .acc_val(acc_q),
    .literal(literal),
    .carry_in(c_q),
    .rot_res(rot_res),
    .rot_carry(rot_carry),
    .sub_res(sub_res),
    .sub_carry(sub_carry),
    .sub_dcarry(sub_dcarry),
    .sub_zero(sub_zero)
  );

  // Accumulator
  always_ff @(posedge core_clk) begin
    if (srst) begin
      acc_q <= `RSSE_RST_ACC;
    end else if (exec && op == rotate_right_carry_op && !dest) begin
      acc_q <= rot_res; // RQ2
    end else if (exec && op == literal_minus_acc_op) begin
      acc_q <= sub_res; // RQ7
    end else if (wr && paddr == `RSSE_OFS_ACC) begin
      acc_q <= pwdata[DATA_W-1:0];
    end
  end

  // Selected file register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      file_q <= `RSSE_RST_FILE;
    end else if (exec && op == rotate_right_carry_op && dest) begin
      file_q <= rot_res; // RQ2
    end else if (wr && paddr == `RSSE_OFS_FILE) begin
      file_q <= pwdata[DATA_W-1:0];
    end
  end

  // Arithmetic flags; sleep leaves them alone
  always_ff @(posedge core_clk) begin
    if (srst) begin
      c_q <= 1'b0;
      dc_q <= 1'b0;
      z_q <= 1'b0;
    end else if (exec && op == rotate_right_carry_op) begin
      c_q <= rot_carry; // RQ1
    end else if (exec && op == literal_minus_acc_op) begin
      c_q <= sub_carry; // RQ8
      dc_q <= sub_dcarry; // RQ9
      z_q <= sub_zero; // RQ8
    end else if (wr && paddr == `RSSE_OFS_STATUS) begin
      c_q <= pwdata[`RSSE_ST_C];
      dc_q <= pwdata[`RSSE_ST_DC];
      z_q <= pwdata[`RSSE_ST_Z];
    end
  end

  // Power-down flag: set at reset, cleared by sleep
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pd_q <= `RSSE_RST_PD;
    end else if (exec && op == sleep_op) begin
      pd_q <= 1'b0; // RQ10
    end else if (wr && paddr == `RSSE_OFS_STATUS) begin
      pd_q <= pwdata[`RSSE_ST_PD];
    end
  end

  // Sleep state; a wake source already high wakes at once
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_q <= rsse_running;
    end else begin
      unique case (state_q)
        rsse_running: begin
          if (exec && op == sleep_op) begin
            state_q <= rsse_asleep; // RQ3
          end
        end
        rsse_asleep: begin
          if (wake_irq) begin
            state_q <= rsse_running; // RQ4
          end
        end
      endcase
    end
  end

  // The first command after a wake is swallowed as a no-operation
  always_ff @(posedge core_clk) begin
    if (srst) begin
      skip_q <= 1'b0;
    end else if (state_q == rsse_asleep && wake_irq) begin
      skip_q <= 1'b1; // RQ6
    end else if (cmd_wr) begin
      skip_q <= 1'b0;
    end
  end

  // Captured in the setup cycle so read data leaves a flop with no wait;
  // a wake at that very edge shows on the next status read
  always_ff @(posedge core_clk) begin
    if (srst) begin
      prdata_q <= 32'h0000_0000;
    end else begin
      prdata_q <= 32'h0000_0000;
      if (rd_setup) begin
        if (paddr == `RSSE_OFS_ACC) begin
          prdata_q[DATA_W-1:0] <= acc_q;
        end else if (paddr == `RSSE_OFS_FILE) begin
          prdata_q[DATA_W-1:0] <= file_q;
        end else if (paddr == `RSSE_OFS_STATUS) begin
          prdata_q[`RSSE_ST_C] <= c_q;
          prdata_q[`RSSE_ST_DC] <= dc_q;
          prdata_q[`RSSE_ST_Z] <= z_q;
          prdata_q[`RSSE_ST_PD] <= pd_q;
          prdata_q[`RSSE_ST_ASLEEP] <= (state_q == rsse_asleep);
        end
      end
    end
  end

  assign prdata = prdata_q;
  assign osc_run = (state_q == rsse_running);
  assign acc_out = acc_q;
  assign file_out = file_q;

  property p_rrf_file;
    @(posedge core_clk) disable iff (srst)
    (exec && op == rotate_right_carry_op && dest) |=>
      (file_q == {$past(c_q), $past(file_q[DATA_W-1:1])}) &&
      (c_q == $past(file_q[0]));
  endproperty
  a_rrf_file: assert property (p_rrf_file) // RQ1
    else $error("rotate into file register wrong");

  property p_rrf_acc;
    @(posedge core_clk) disable iff (srst)
    (exec && op == rotate_right_carry_op && !dest) |=>
      $stable(file_q) && acc_q == {$past(c_q), $past(file_q[DATA_W-1:1])};
  endproperty
  a_rrf_acc: assert property (p_rrf_acc) // RQ2
    else $error("rotate to accumulator wrong");

  property p_sleep_halt;
    @(posedge core_clk) disable iff (srst)
    (exec && op == sleep_op) |=> !osc_run;
  endproperty
  a_sleep_halt: assert property (p_sleep_halt) // RQ3
    else $error("oscillator not halted after sleep");

  property p_sleep_flags;
    @(posedge core_clk) disable iff (srst)
    (exec && op == sleep_op) |=> $stable(c_q) && $stable(dc_q) &&
      $stable(z_q) && $stable(acc_q) && $stable(file_q);
  endproperty
  a_sleep_flags: assert property (p_sleep_flags) // RQ3
    else $error("sleep changed an arithmetic flag");

  property p_wake;
    @(posedge core_clk) disable iff (srst)
    (!osc_run && wake_irq) |=> osc_run ##1 (osc_run throughout !exec[*1]);
  endproperty
  a_wake: assert property (p_wake) // RQ4
    else $error("no wake on external interrupt");

  property p_stay_asleep;
    @(posedge core_clk) disable iff (srst)
    (!osc_run && !wake_irq) |=> !osc_run;
  endproperty
  a_stay_asleep: assert property (p_stay_asleep) // RQ4
    else $error("woke without interrupt");

  property p_wake_skip;
    @(posedge core_clk) disable iff (srst)
    (skip_q && cmd_wr) |=> osc_run && $stable(acc_q) && $stable(file_q) &&
      $stable(c_q) && $stable(dc_q) && $stable(z_q) && $stable(pd_q);
  endproperty
  a_wake_skip: assert property (p_wake_skip) // RQ6
    else $error("command after wake was executed");

  property p_cmd_asleep;
    @(posedge core_clk) disable iff (srst)
    (cmd_wr && !osc_run) |=> $stable(acc_q) && $stable(file_q) &&
      $stable(c_q) && $stable(dc_q) && $stable(z_q) && $stable(pd_q);
  endproperty
  a_cmd_asleep: assert property (p_cmd_asleep) // RQ3
    else $error("command executed while asleep");

  property p_sub_acc;
    @(posedge core_clk) disable iff (srst)
    (exec && op == literal_minus_acc_op) |=>
      acc_q == DATA_W'($past(literal) - $past(acc_q));
  endproperty
  a_sub_acc: assert property (p_sub_acc) // RQ7
    else $error("literal subtract result wrong");

  property p_sub_flags;
    @(posedge core_clk) disable iff (srst)
    (exec && op == literal_minus_acc_op) |=>
      (c_q == ($past(literal) >= $past(acc_q))) && (z_q == (acc_q == '0));
  endproperty
  a_sub_flags: assert property (p_sub_flags) // RQ8
    else $error("subtract carry or zero wrong");

  property p_sub_dc;
    @(posedge core_clk) disable iff (srst)
    (exec && op == literal_minus_acc_op) |=>
      dc_q == ($past(literal[3:0]) >= $past(acc_q[3:0]));
  endproperty
  a_sub_dc: assert property (p_sub_dc) // RQ9
    else $error("subtract digit carry wrong");

  property p_pd_clear;
    @(posedge core_clk) disable iff (srst)
    (exec && op == sleep_op) |=> !pd_q;
  endproperty
  a_pd_clear: assert property (p_pd_clear) // RQ10
    else $error("power-down flag not cleared");

  c_rrf: cover property (@(posedge core_clk) disable iff (srst)
    exec && op == rotate_right_carry_op);
  c_sub_borrow: cover property (@(posedge core_clk) disable iff (srst)
    exec && op == literal_minus_acc_op && !sub_carry);
  c_sleep_wake: cover property (@(posedge core_clk) disable iff (srst)
    (exec && op == sleep_op) ##[1:20] osc_run);
  c_unmapped: cover property (@(posedge core_clk) disable iff (srst)
    pslverr);

endmodule

//--- test_rotate_subtract_sleep_exec.sv
// Self-checking bench for the rotate, subtract and sleep execution block.
// Assumes the map header offsets and the zero-wait APB slave in the notes.
`timescale 1ns/1ps
`include "rsse_map.svh"
module test_rotate_subtract_sleep_exec
  import rsse_pkg::*;
;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic wake_irq = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic osc_run;
  logic [7:0] acc_out;
  logic [7:0] file_out;
  logic [31:0] rd;
  logic err;
  logic [7:0] exp_v;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [7:0] lits [5] = '{8'h02, 8'h02, 8'h02, 8'h10, 8'h37};
  logic [7:0] accs [5] = '{8'h01, 8'h02, 8'h03, 8'h01, 8'h48};

  rsse_exec i_rsse_exec (
    .core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wake_irq(wake_irq),
    .osc_run(osc_run), .acc_out(acc_out), .file_out(file_out)
  );

  initial begin
    forever #20 core_clk = ~core_clk;
  end

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Bound is far above the roughly 165 cycles the sequence needs
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      $display("BAD cycle_limit expected below %0d seen %0d", 5000, cyc);
      results();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // Waits as long as the slave needs; only the cycle limit ends a hang
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd_chk(input string what, input logic [11:0] a,
                        input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000);
    chk(what, exp, rd);
  endtask

  function automatic logic [31:0] cmd(input rsse_op_type op,
                                      input logic dst, input logic [7:0] lit);
    return {16'h0000, lit, 5'h00, dst, op};
  endfunction

  function automatic logic [31:0] stw(input logic asl, input logic pd,
                                      input logic z, input logic dc,
                                      input logic c);
    return {27'h0000000, asl, pd, z, dc, c};
  endfunction

  initial begin
    repeat (10) @(posedge core_clk);
    srst <= 1'b0;
    rd_chk("acc", `RSSE_OFS_ACC, 32'h0000_0000);
    rd_chk("file", `RSSE_OFS_FILE, 32'h0000_0000);
    rd_chk("status", `RSSE_OFS_STATUS, stw(0, 1, 0, 0, 0));
    chk("osc_run", 32'h1, {31'h0, osc_run});
    $display("test reset values done");

    wr(`RSSE_OFS_ACC, 32'h0000_0088);
    wr(`RSSE_OFS_FILE, 32'h0000_0095);
    wr(`RSSE_OFS_CMD, cmd(rotate_right_carry_op, 1'b0, 8'h00));
    rd_chk("acc", `RSSE_OFS_ACC, 32'h0000_004a);
    rd_chk("file", `RSSE_OFS_FILE, 32'h0000_0095);
    rd_chk("status", `RSSE_OFS_STATUS, stw(0, 1, 0, 0, 1));
    wr(`RSSE_OFS_CMD, cmd(rotate_right_carry_op, 1'b1, 8'h00));
    rd_chk("file", `RSSE_OFS_FILE, 32'h0000_00ca);
    chk("acc_out", 32'h4a, {24'h0, acc_out});
    chk("file_out", 32'hca, {24'h0, file_out});
    wr(`RSSE_OFS_CMD, cmd(no_operation_op, 1'b1, 8'h00));
    rd_chk("status", `RSSE_OFS_STATUS, stw(0, 1, 0, 0, 1));
    rd_chk("acc", `RSSE_OFS_ACC, 32'h0000_004a);
    $display("test rotate done");

    for (int i = 0; i < 5; i++) begin
      wr(`RSSE_OFS_ACC, {24'h0, accs[i]});
      wr(`RSSE_OFS_CMD, cmd(literal_minus_acc_op, 1'b0, lits[i]));
      exp_v = lits[i] - accs[i];
      rd_chk("acc", `RSSE_OFS_ACC, {24'h0, exp_v});
      rd_chk("status", `RSSE_OFS_STATUS, stw(0, 1, exp_v == 8'h00,
             lits[i][3:0] >= accs[i][3:0], lits[i] >= accs[i]));
    end
    $display("test subtract done");

    wr(`RSSE_OFS_STATUS, stw(0, 1, 0, 0, 1));
    wr(`RSSE_OFS_ACC, 32'h0000_0011);
    wr(`RSSE_OFS_FILE, 32'h0000_003c);
    wr(`RSSE_OFS_CMD, cmd(sleep_op, 1'b0, 8'h00));
    @(posedge core_clk);
    chk("osc_run", 32'h0, {31'h0, osc_run});
    rd_chk("status", `RSSE_OFS_STATUS, stw(1, 0, 0, 0, 1));
    wr(`RSSE_OFS_CMD, cmd(literal_minus_acc_op, 1'b0, 8'h55));
    rd_chk("acc", `RSSE_OFS_ACC, 32'h0000_0011);
    chk("osc_run", 32'h0, {31'h0, osc_run});
    @(posedge core_clk);
    wake_irq <= 1'b1;
    @(posedge core_clk);
    wake_irq <= 1'b0;
    @(posedge core_clk);
    chk("osc_run", 32'h1, {31'h0, osc_run});
    // First command after waking lands in the no-operation slot
    wr(`RSSE_OFS_CMD, cmd(rotate_right_carry_op, 1'b1, 8'h00));
    rd_chk("file", `RSSE_OFS_FILE, 32'h0000_003c);
    wr(`RSSE_OFS_CMD, cmd(rotate_right_carry_op, 1'b1, 8'h00));
    rd_chk("file", `RSSE_OFS_FILE, 32'h0000_009e);
    rd_chk("status", `RSSE_OFS_STATUS, stw(0, 0, 0, 0, 0));
    $display("test sleep and wake done");

    xfer(1'b0, 12'h010, 32'h0000_0000);
    chk("slverr", 32'h1, {31'h0, err});
    chk("unmapped read", 32'h0000_0000, rd);
    wr(12'h010, 32'h0000_00ff);
    chk("slverr", 32'h1, {31'h0, err});
    rd_chk("cmd", `RSSE_OFS_CMD, 32'h0000_0000);
    rd_chk("acc", `RSSE_OFS_ACC, 32'h0000_0011);
    chk("slverr", 32'h0, {31'h0, err});
    $display("test unmapped access done");
    results();
  end
endmodule
